// [fsag_array_model.sv]
// Purpose: behavioural program array behind the guard
// Assumes: unwritten bytes read as erased
// Notes: one byte preset so that a full erase is visible
`include "fsag_params.svh"
module fsag_array_model #(
    parameter int ARRAY_KBYTES = 32
) (
    // array side
    input wire logic clk_sys,
    input wire logic arr_wr,
    input wire logic [`FSAG_ADDR_W-1:0] arr_addr,
    input wire logic [7:0] arr_data,
    input wire logic arr_erase,
    input wire logic [3:0] arr_erase_mask,
    input wire logic [`FSAG_ADDR_W-1:0] ext_rd_addr,
    output logic [7:0] array_rd_data
);
    localparam int BASE = 65536 - ARRAY_KBYTES * 1024;
    logic [7:0] mem [int];
    int upd = 0;
    initial mem[16'hF000] = 8'h12;
    always @(posedge clk_sys) begin
        if (arr_wr)
            mem[arr_addr] = arr_data;
        for (int i = 0; i < 3; i++)
            if (arr_erase && arr_erase_mask[i])
                for (int a = (i == 2) ? BASE : 61440 - 4096 * i; a <= 65535 - 4096 * i; a++)
                    mem.delete(a);
    end
    // refresh off the rising edge so the guard never samples a changing byte
    always @(negedge clk_sys) upd++;
    always @(ext_rd_addr or upd) array_rd_data = mem.exists(ext_rd_addr) ? mem[ext_rd_addr] : `FSAG_ERASED_BYTE;
endmodule

// [fsag_assertions.sv]
// Purpose: port checks for fsag_guard
// Assumes: one clock domain, reset active low
// Notes: bound from the bench top file
`include "fsag_params.svh"
module fsag_chk #(
    parameter int PROG_CYCLES = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // requests
    input wire fsag_pkg::fsag_mode_t mode,
    input wire logic programming_supply,
    input wire logic cmd_valid,
    // answers
    input wire logic arr_wr,
    input wire logic [`FSAG_ADDR_W-1:0] arr_addr,
    input wire logic arr_erase,
    input wire logic [3:0] arr_erase_mask,
    input wire logic busy,
    input wire logic done,
    input wire logic rejected,
    input wire logic unlocked,
    input wire logic protect_active,
    input wire logic option_wr,
    input wire logic option_wr_value
);
    import fsag_pkg::*;
    // --------------------------------
    // properties
    // --------------------------------
    localparam int DONE_MAX = PROG_CYCLES + 8;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence take_s;
        cmd_valid && !busy;
    endsequence
    sequence act_s;
        arr_wr || arr_erase;
    endsequence
    run_refuse_a: assert property (take_s ##0 mode == FSAG_MODE_RUN |=> rejected && !arr_wr && !arr_erase)
        else $error("run mode request not refused");
    key_needed_a: assert property (take_s ##0 !unlocked |=> rejected && !arr_wr && !arr_erase)
        else $error("locked request not refused");
    relock_a: assert property (arr_wr || arr_erase || rejected |-> !unlocked)
        else $error("guard stays unlocked after a command");
    protect_wr_a: assert property (act_s ##0 !option_wr |-> $past(protect_active) == 1'b0)
        else $error("array altered while protected");
    iap_sect0_a: assert property (arr_erase && mode == FSAG_MODE_IAP |-> !arr_erase_mask[0])
        else $error("sector 0 erased in application mode");
    iap_addr_a: assert property (arr_wr && mode == FSAG_MODE_IAP |-> arr_addr < `FSAG_SECT0_BASE)
        else $error("sector 0 written in application mode");
    unprot_erase_a: assert property (option_wr && !option_wr_value && protect_active |-> arr_erase && arr_erase_mask == 4'h7)
        else $error("protection removed without full erase");
    supply_a: assert property (act_s |-> $past(programming_supply, 3))
        else $error("array altered without supply");
    done_bound_a: assert property ($rose(busy) |-> ##[1:DONE_MAX] done)
        else $error("operation never completes");
endmodule

// [fsag_guard.sv]
// Purpose: sector access and protection guard for on-chip program memory
// Assumes: array storage is outside; this block issues byte writes and erase strobes
// Notes: the supply is a pin input passed through four flip-flops, the last loading only when the two before it agree
`include "fsag_params.svh"

module fsag_guard #(
    parameter int ARRAY_KBYTES = 32,
    parameter int PROG_CYCLES = `FSAG_PROG_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // mode and supply
    input wire fsag_pkg::fsag_mode_t mode,
    input wire logic programming_supply,
    input wire logic readout_protect_option,
    // unlock key writes
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    // command request
    input wire logic cmd_valid,
    input wire fsag_pkg::fsag_cmd_t cmd,
    input wire logic [`FSAG_ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic [1:0] cmd_sector,
    input wire logic cmd_option_value,
    // external read request
    input wire logic ext_rd,
    input wire logic [`FSAG_ADDR_W-1:0] ext_rd_addr,
    input wire logic [7:0] array_rd_data,
    // array control
    output logic arr_wr,
    output logic [`FSAG_ADDR_W-1:0] arr_addr,
    output logic [7:0] arr_data,
    output logic arr_erase,
    output logic [3:0] arr_erase_mask,
    // status
    output logic busy,
    output logic done,
    output logic rejected,
    output logic unlocked,
    output logic protect_active,
    output logic option_wr,
    output logic option_wr_value,
    output logic [7:0] ext_rd_data
);
    import fsag_pkg::*;

    localparam logic [15:0] PROG_CNT = 16'(PROG_CYCLES);

    // ----------------------------------------------------------------
    // supply synchroniser
    // ----------------------------------------------------------------
    logic sup_s1_ff, sup_s2_ff, sup_s3_ff, sup_ok_ff;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sup_s1_ff <= 1'b0;
            sup_s2_ff <= 1'b0;
            sup_s3_ff <= 1'b0;
            sup_ok_ff <= 1'b0;
        end else begin
            sup_s1_ff <= programming_supply;
            sup_s2_ff <= sup_s1_ff;
            sup_s3_ff <= sup_s2_ff;
            if (sup_s2_ff == sup_s3_ff) begin
                sup_ok_ff <= sup_s3_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // sector map
    // ----------------------------------------------------------------
    // sector 2 covers everything below sector 1; no sector 3 exists
    wire [2:0] sect_present = (ARRAY_KBYTES <= 4) ? 3'h1 : (ARRAY_KBYTES <= 8) ? 3'h3 : 3'h7;
    wire [`FSAG_ADDR_W-1:0] arr_base = `FSAG_ADDR_W'(17'h10000 - 17'(ARRAY_KBYTES * 1024));
    wire in_array = cmd_addr >= arr_base;
    wire [1:0] addr_sector = (cmd_addr >= `FSAG_SECT0_BASE) ? 2'h0 :
                             (cmd_addr >= `FSAG_SECT1_BASE) ? 2'h1 : 2'h2;
    wire [1:0] tgt_sector = (cmd == FSAG_CMD_SECT_ERASE) ? cmd_sector : addr_sector;
    wire sect_exists = (tgt_sector != 2'h3) && sect_present[tgt_sector];

    // ----------------------------------------------------------------
    // unlock guard
    // ----------------------------------------------------------------
    logic [1:0] key_stage_ff, nxt_key_stage;
    wire cmd_take;
    always_comb begin
        nxt_key_stage = key_stage_ff;
        if (cmd_take) begin
            nxt_key_stage = 2'h0;
        end else if (key_wr) begin
            if (key_stage_ff == 2'h0 && key_data == `FSAG_KEY1) begin
                nxt_key_stage = 2'h1;
            end else if (key_stage_ff == 2'h1 && key_data == `FSAG_KEY2) begin
                nxt_key_stage = 2'h2;
            end else begin
                nxt_key_stage = 2'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // permission decode
    // ----------------------------------------------------------------
    logic prot_ff;
    wire mode_ok = (mode != FSAG_MODE_RUN);
    wire full_mode = (mode == FSAG_MODE_TOOL) || (mode == FSAG_MODE_ICP);
    wire sect_ok = full_mode || (tgt_sector != 2'h0);
    wire is_option = (cmd == FSAG_CMD_OPTION);
    wire is_mass = (cmd == FSAG_CMD_MASS_ERASE);
    wire prot_unlock = is_option && prot_ff && !cmd_option_value;
    // only the option write that drops protection gets through a protected array
    wire prot_ok = !prot_ff || prot_unlock;
    wire area_ok = is_option ? full_mode :
                   is_mass ? full_mode :
                   (sect_ok && sect_exists && (cmd == FSAG_CMD_SECT_ERASE || in_array));
    wire permit = mode_ok && sup_ok_ff && (key_stage_ff == 2'h2) && prot_ok && area_ok;

    // ----------------------------------------------------------------
    // operation sequencer
    // ----------------------------------------------------------------
    fsag_state_t state_ff, nxt_state;
    logic [15:0] cnt_ff;
    assign cmd_take = cmd_valid && (state_ff == FSAG_ST_IDLE);
    wire accept = cmd_take && permit;
    wire refuse = cmd_take && !permit;
    wire cnt_end = (cnt_ff == 16'h0001);
    wire [3:0] sect_mask = 4'(4'h1 << tgt_sector);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FSAG_ST_IDLE: begin
                if (accept) begin
                    nxt_state = (cmd == FSAG_CMD_PROG) ? FSAG_ST_PROG : FSAG_ST_ERASE;
                end
            end
            FSAG_ST_PROG: nxt_state = FSAG_ST_WAIT;
            FSAG_ST_ERASE: nxt_state = FSAG_ST_WAIT;
            FSAG_ST_WAIT: begin
                if (cnt_end) begin
                    nxt_state = FSAG_ST_DONE;
                end
            end
            FSAG_ST_DONE: nxt_state = FSAG_ST_IDLE;
            default: nxt_state = FSAG_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= FSAG_ST_IDLE;
            key_stage_ff <= 2'h0;
            cnt_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            key_stage_ff <= nxt_key_stage;
            if (state_ff == FSAG_ST_PROG || state_ff == FSAG_ST_ERASE) begin
                cnt_ff <= PROG_CNT;
            end else if (cnt_ff != 16'h0000) begin
                cnt_ff <= cnt_ff - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // protection state
    // ----------------------------------------------------------------
    // option byte is caught one clock after reset release, never under the reset itself
    logic prot_loaded_ff;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prot_ff <= 1'b1;
            prot_loaded_ff <= 1'b0;
        end else begin
            prot_loaded_ff <= 1'b1;
            if (!prot_loaded_ff) begin
                prot_ff <= readout_protect_option;
            end else if (accept && is_option) begin
                prot_ff <= cmd_option_value;
            end
        end
    end

    // ----------------------------------------------------------------
    // array strobes
    // ----------------------------------------------------------------
    wire mass_now = accept && (is_mass || prot_unlock);
    wire sect_now = accept && (cmd == FSAG_CMD_SECT_ERASE);
    wire prog_now = accept && (cmd == FSAG_CMD_PROG);
    wire [3:0] nxt_mask = mass_now ? {1'b0, sect_present} : sect_now ? sect_mask : 4'h0;
    wire rd_block = prot_ff;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            arr_wr <= 1'b0;
            arr_addr <= `FSAG_ADDR_W'h0000;
            arr_data <= 8'h00;
            arr_erase <= 1'b0;
            arr_erase_mask <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
            rejected <= 1'b0;
            unlocked <= 1'b0;
            protect_active <= 1'b1;
            option_wr <= 1'b0;
            option_wr_value <= 1'b0;
            ext_rd_data <= 8'h00;
        end else begin
            arr_wr <= prog_now;
            if (prog_now) begin
                arr_addr <= cmd_addr;
                arr_data <= cmd_data;
            end
            arr_erase <= mass_now || sect_now;
            arr_erase_mask <= nxt_mask;
            busy <= (nxt_state != FSAG_ST_IDLE);
            done <= (state_ff == FSAG_ST_WAIT) && cnt_end;
            rejected <= refuse;
            unlocked <= (nxt_key_stage == 2'h2);
            protect_active <= prot_ff;
            option_wr <= accept && is_option;
            option_wr_value <= (accept && is_option) ? cmd_option_value : option_wr_value;
            if (ext_rd) begin
                ext_rd_data <= rd_block ? `FSAG_ERASED_BYTE : array_rd_data;
            end
        end
    end
endmodule

// [fsag_params.svh]
// Purpose: constants for the flash sector access guard
// Assumes: 16-bit address space, program memory at its top end
// Notes: unlock keys and timing counts are plain choices
`ifndef FSAG_PARAMS_SVH
`define FSAG_PARAMS_SVH

// ----------------------------------------------------------------
// array layout
// ----------------------------------------------------------------
`define FSAG_ADDR_W 16
`define FSAG_SECT0_BASE 16'hF000
`define FSAG_SECT1_BASE 16'hE000
`define FSAG_SECT_BYTES 16'h1000
`define FSAG_ERASED_BYTE 8'hFF

// ----------------------------------------------------------------
// unlock guard keys
// ----------------------------------------------------------------
`define FSAG_KEY1 8'h56
`define FSAG_KEY2 8'hAE

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSAG_CLK_MHZ 125
`define FSAG_PROG_TIME_US 2
`define FSAG_PROG_CYC (`FSAG_PROG_TIME_US * `FSAG_CLK_MHZ)

`endif

// [fsag_pkg.sv]
// Purpose: types for the flash sector access guard
// Assumes: nothing beyond the params header
// Notes: one-hot state codes
package fsag_pkg;
    typedef enum logic [1:0] {
        FSAG_MODE_TOOL = 2'h0,
        FSAG_MODE_ICP = 2'h1,
        FSAG_MODE_IAP = 2'h2,
        FSAG_MODE_RUN = 2'h3
    } fsag_mode_t;

    typedef enum logic [1:0] {
        FSAG_CMD_PROG = 2'h0,
        FSAG_CMD_SECT_ERASE = 2'h1,
        FSAG_CMD_MASS_ERASE = 2'h2,
        FSAG_CMD_OPTION = 2'h3
    } fsag_cmd_t;

    typedef enum logic [4:0] {
        FSAG_ST_IDLE = 5'h01,
        FSAG_ST_PROG = 5'h02,
        FSAG_ST_ERASE = 5'h04,
        FSAG_ST_WAIT = 5'h08,
        FSAG_ST_DONE = 5'h10
    } fsag_state_t;
endpackage

// [tb_top.sv]
// Purpose: self-checking bench for fsag_guard
// Assumes: 32K array, PROG_CYCLES cut to 4
// Notes: inputs move on the falling edge
`include "fsag_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsag_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, programming_supply = 1'b1, readout_protect_option = 1'b1;
    logic key_wr = 1'b0, cmd_valid = 1'b0, cmd_option_value = 1'b0, ext_rd = 1'b0;
    fsag_mode_t mode = FSAG_MODE_TOOL;
    fsag_cmd_t cmd = FSAG_CMD_PROG;
    logic [7:0] key_data = 8'h00, cmd_data = 8'h00, array_rd_data, arr_data, ext_rd_data;
    logic [15:0] cmd_addr = 16'h0000, ext_rd_addr = 16'h0000, arr_addr;
    logic [1:0] cmd_sector = 2'h0;
    logic [3:0] arr_erase_mask;
    logic arr_wr, arr_erase, busy, done, rejected, unlocked, protect_active, option_wr, option_wr_value;
    int num_errors = 0, check_count = 0;
    fsag_guard #(.ARRAY_KBYTES(32), .PROG_CYCLES(4)) u_fsag_guard (.*);
    fsag_array_model #(.ARRAY_KBYTES(32)) u_fsag_array_model (.*);
    initial forever #4 clk_sys = ~clk_sys;
    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // sector number rides on the low address bits, option value on data bit 0
    task automatic op(input fsag_cmd_t c, input logic [15:0] a, input logic [7:0] d, input logic unl,
                      input logic ok, input logic [3:0] m);
        key_wr = unl;
        key_data = `FSAG_KEY1;
        @(negedge clk_sys);
        key_data = `FSAG_KEY2;
        @(negedge clk_sys);
        key_wr = 1'b0;
        {cmd_valid, cmd, cmd_addr, cmd_data, cmd_sector, cmd_option_value} = {1'b1, c, a, d, a[1:0], d[0]};
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        // rejected and the erase mask stand for one cycle only, so look right away
        chk("rejected", 16'(!ok), 16'(rejected));
        chk("arr_erase_mask", 16'(m), 16'(arr_erase_mask));
        for (int i = 0; i < 40 && ok && done !== 1'b1; i++) @(negedge clk_sys);
        chk("done", 16'(ok), 16'(done));
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        ext_rd = 1'b1;
        ext_rd_addr = a;
        @(negedge clk_sys);
        ext_rd = 1'b0;
        chk("ext_rd_data", 16'(exp), 16'(ext_rd_data));
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_protected();
        rd(16'hF000, 8'hFF);
        op(FSAG_CMD_PROG, 16'hE100, 8'h5A, 1'b1, 1'b0, 4'h0);
        op(FSAG_CMD_OPTION, 16'h0000, 8'h00, 1'b1, 1'b1, 4'h7);
        chk("protect_active", 16'h0, 16'(protect_active));
        rd(16'hF000, 8'hFF);
    endtask
    task automatic t_tool();
        op(FSAG_CMD_PROG, 16'hE123, 8'hA5, 1'b1, 1'b1, 4'h0);
        op(FSAG_CMD_PROG, 16'hF010, 8'h3C, 1'b1, 1'b1, 4'h0);
        op(FSAG_CMD_PROG, 16'hE124, 8'h11, 1'b0, 1'b0, 4'h0);
        rd(16'hE123, 8'hA5);
        rd(16'hE124, 8'hFF);
    endtask
    task automatic t_sector();
        mode = FSAG_MODE_ICP;
        op(FSAG_CMD_SECT_ERASE, 16'h0001, 8'h00, 1'b1, 1'b1, 4'h2);
        rd(16'hE123, 8'hFF);
        rd(16'hF010, 8'h3C);
    endtask
    task automatic t_iap();
        mode = FSAG_MODE_IAP;
        op(FSAG_CMD_PROG, 16'hF020, 8'h44, 1'b1, 1'b0, 4'h0);
        op(FSAG_CMD_SECT_ERASE, 16'h0000, 8'h00, 1'b1, 1'b0, 4'h0);
        op(FSAG_CMD_MASS_ERASE, 16'h0000, 8'h00, 1'b1, 1'b0, 4'h0);
        op(FSAG_CMD_PROG, 16'hEFFF, 8'h77, 1'b1, 1'b1, 4'h0);
        rd(16'hEFFF, 8'h77);
    endtask
    task automatic t_limits();
        programming_supply = 1'b0;
        repeat (4) @(negedge clk_sys);
        op(FSAG_CMD_PROG, 16'hE000, 8'h01, 1'b1, 1'b0, 4'h0);
        programming_supply = 1'b1;
        repeat (4) @(negedge clk_sys);
        mode = FSAG_MODE_RUN;
        op(FSAG_CMD_PROG, 16'hE000, 8'h01, 1'b1, 1'b0, 4'h0);
        mode = FSAG_MODE_TOOL;
        op(FSAG_CMD_PROG, 16'h7FFF, 8'h01, 1'b1, 1'b0, 4'h0);
        op(FSAG_CMD_SECT_ERASE, 16'h0003, 8'h00, 1'b1, 1'b0, 4'h0);
        op(FSAG_CMD_SECT_ERASE, 16'h0002, 8'h00, 1'b1, 1'b1, 4'h4);
        rd(16'hEFFF, 8'h77);
        op(FSAG_CMD_MASS_ERASE, 16'h0000, 8'h00, 1'b1, 1'b1, 4'h7);
        rd(16'hEFFF, 8'hFF);
        rd(16'hF010, 8'hFF);
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        chk("protect_active", 16'h1, 16'(protect_active));
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        t_protected();
        t_tool();
        t_sector();
        t_iap();
        t_limits();
        wrap_up();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end
endmodule
bind fsag_guard fsag_chk #(.PROG_CYCLES(PROG_CYCLES)) u_fsag_chk (.*);
